// ==== hdl/wdmf_top.sv ====
// Watchdog counter, write-once mode register and fault routing over AXI4-Lite.
`default_nettype none
module wdmf_top #(
  parameter int SLOW_DIV = wdmf_pkg::SLOW_DIV
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [wdmf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdmf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debugState,
  input wire logic idleState,
  output logic irq,
  output logic faultIrq,
  output logic allReset,
  output logic procReset
);
  import wdmf_pkg::*;

  typedef struct packed {
    logic awDone;
    logic [ADDR_W-1:0] awAddr;
    logic wDone;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] mode;
    logic locked;
    logic [CNT_W-1:0] cnt;
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic faultIrq;
    logic allReset;
    logic procReset;
    logic irq;
  } wdmf_state_t;

  wdmf_state_t s_q, s_d;
  logic slowTick;

  wdmf_tick #(
    .DIV(SLOW_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .reset(reset),
    .tick(slowTick)
  );

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = (a == OFF_MODE) || (a == OFF_CMD) || (a == OFF_STAT) ||
      (a == OFF_IRQ) || (a == OFF_MASK);
  endfunction : known

  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  logic doWrite;
  logic doRead;
  logic restartCmd;
  logic fault;
  logic [CNT_W-1:0] reloadVal;
  logic [CNT_W-1:0] deltaVal;
  logic running;
  logic underflow;
  logic restartErr;
  logic [EV_W-1:0] events;

  always_comb begin
    s_d = s_q;
    reloadVal = s_q.mode[RELOAD_LSB +: CNT_W];
    deltaVal = s_q.mode[DELTA_LSB +: CNT_W];
    doWrite = s_q.awDone && s_q.wDone && !s_q.bValid;
    doRead = s_axi_arvalid && !s_q.rValid;
    restartCmd = doWrite && (s_q.awAddr == OFF_CMD) && s_q.wStrb[0] &&
      s_q.wData[RESTART_BIT];
    // Halts gate the tick only, so a pending restart still acts.
    running = !s_q.mode[DIS_BIT] && slowTick &&
      !(s_q.mode[DBGHLT_BIT] && debugState) &&
      !(s_q.mode[IDLEHLT_BIT] && idleState);
    restartErr = restartCmd && !s_q.mode[DIS_BIT] && (s_q.cnt > deltaVal);
    underflow = running && (s_q.cnt == '0);
    events = '0;
    events[EV_UNDER] = underflow;
    events[EV_ERR] = restartErr;
    fault = underflow || restartErr;

    // Write channels accepted independently, in either order.
    if (s_axi_awvalid && !s_q.awDone) begin
      s_d.awDone = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wDone) begin
      s_d.wDone = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (doWrite) begin
      s_d.awDone = 1'b0;
      s_d.wDone = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = known(s_q.awAddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.awAddr == OFF_MODE && !s_q.locked) begin
        s_d.mode = merge(s_q.mode, s_q.wData, s_q.wStrb) & MODE_MASK;
        s_d.locked = 1'b1;
      end
      if (s_q.awAddr == OFF_MASK && s_q.wStrb[0]) begin
        s_d.mask = s_q.wData[EV_W-1:0];
      end
    end

    // Counter: an in-window restart wins, else reload at underflow or step on the slow tick.
    if (restartCmd && !s_q.mode[DIS_BIT] && s_q.cnt <= deltaVal) begin
      s_d.cnt = reloadVal;
    end else if (underflow) begin
      s_d.cnt = reloadVal;
    end else if (running) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end

    // Status clear by one; a new event wins over the clear.
    if (doWrite && s_q.awAddr == OFF_STAT && s_q.wStrb[0]) begin
      s_d.stat = s_q.stat & ~s_q.wData[EV_W-1:0];
    end
    s_d.stat = s_d.stat | events;
    // A set mask bit hides its status bit from the interrupt line.
    s_d.irq = |(s_d.stat & ~s_d.mask);

    if (fault && s_q.mode[FIEN_BIT]) begin
      s_d.faultIrq = 1'b1;
    end
    if (doWrite && s_q.awAddr == OFF_STAT && s_q.wStrb[0] &&
      !fault) begin
      s_d.faultIrq = 1'b0;
    end
    // Reset pulses last one cycle; the reset controller stretches them.
    s_d.allReset = fault && s_q.mode[RSTEN_BIT] && !s_q.mode[PROC_BIT];
    s_d.procReset = fault && s_q.mode[RSTEN_BIT];

    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    // The command register is write-only, so it reads back as zero.
    if (doRead) begin
      s_d.rValid = 1'b1;
      s_d.rResp = known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rData = 32'h0000_0000;
      if (s_axi_araddr == OFF_MODE) begin
        s_d.rData = s_q.mode;
      end
      if (s_axi_araddr == OFF_STAT) begin
        s_d.rData = 32'(s_q.stat);
      end
      if (s_axi_araddr == OFF_IRQ) begin
        s_d.rData = 32'(s_q.irq);
      end
      if (s_axi_araddr == OFF_MASK) begin
        s_d.rData = 32'(s_q.mask);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.mode <= MODE_RESET;
      s_q.cnt <= MODE_RESET[CNT_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  // Checks below watch the registered state; they are off while reset is
  // high because the whole state is reloaded then.
  sequence s_inWindowRestart;
    restartCmd && !s_q.mode[DIS_BIT] && (s_q.cnt <= deltaVal);
  endsequence : s_inWindowRestart

  sequence s_lateRestart;
    restartCmd && !s_q.mode[DIS_BIT] && (s_q.cnt > deltaVal);
  endsequence : s_lateRestart

  sequence s_haltedStep;
    s_q.mode[DBGHLT_BIT] && debugState && !restartCmd;
  endsequence : s_haltedStep

  property p_modeLocked;
    @(posedge core_clk) disable iff (reset)
    s_q.locked |=> (s_q.locked && $stable(s_q.mode));
  endproperty : p_modeLocked
  a_modeLocked: assert property (p_modeLocked)
    else $error("mode register changed after its first write");

  property p_restartReload;
    @(posedge core_clk) disable iff (reset)
    s_inWindowRestart |=> (s_q.cnt == $past(reloadVal));
  endproperty : p_restartReload
  a_restartReload: assert property (p_restartReload)
    else $error("in-window restart did not reload the counter");

  property p_underflowReload;
    @(posedge core_clk) disable iff (reset)
    underflow |=> (s_q.cnt == $past(reloadVal));
  endproperty : p_underflowReload
  a_underflowReload: assert property (p_underflowReload)
    else $error("counter not reloaded after underflow");

  property p_restartErr;
    @(posedge core_clk) disable iff (reset)
    s_lateRestart |=> s_q.stat[EV_ERR];
  endproperty : p_restartErr
  a_restartErr: assert property (p_restartErr)
    else $error("late restart did not flag an error");

  property p_faultIrqSet;
    @(posedge core_clk) disable iff (reset)
    (fault && s_q.mode[FIEN_BIT]) |=> s_q.faultIrq;
  endproperty : p_faultIrqSet
  a_faultIrqSet: assert property (p_faultIrqSet)
    else $error("enabled fault did not raise the fault interrupt");

  property p_faultIrqCause;
    @(posedge core_clk) disable iff (reset)
    $rose(s_q.faultIrq) |-> $past(s_q.mode[FIEN_BIT]);
  endproperty : p_faultIrqCause
  a_faultIrqCause: assert property (p_faultIrqCause)
    else $error("fault interrupt rose while disabled");

  property p_allReset;
    @(posedge core_clk) disable iff (reset)
    (fault && s_q.mode[RSTEN_BIT] && !s_q.mode[PROC_BIT]) |=>
      (s_q.allReset && s_q.procReset);
  endproperty : p_allReset
  a_allReset: assert property (p_allReset)
    else $error("fault did not fire all resets");

  property p_procOnly;
    @(posedge core_clk) disable iff (reset)
    (fault && s_q.mode[RSTEN_BIT] && s_q.mode[PROC_BIT]) |=>
      (s_q.procReset && !s_q.allReset);
  endproperty : p_procOnly
  a_procOnly: assert property (p_procOnly)
    else $error("processor-only fault reset has the wrong scope");

  property p_noReset;
    @(posedge core_clk) disable iff (reset)
    !s_q.mode[RSTEN_BIT] |=> (!s_q.procReset && !s_q.allReset);
  endproperty : p_noReset
  a_noReset: assert property (p_noReset)
    else $error("reset fired with reset enable clear");

  property p_debugHalt;
    @(posedge core_clk) disable iff (reset)
    s_haltedStep |=> $stable(s_q.cnt);
  endproperty : p_debugHalt
  a_debugHalt: assert property (p_debugHalt)
    else $error("counter moved while halted in debug");

  property p_underflowFlag;
    @(posedge core_clk) disable iff (reset)
    underflow |=> s_q.stat[EV_UNDER];
  endproperty : p_underflowFlag
  a_underflowFlag: assert property (p_underflowFlag)
    else $error("underflow not flagged");

  property p_disabled;
    @(posedge core_clk) disable iff (reset)
    s_q.mode[DIS_BIT] |=> $stable(s_q.cnt);
  endproperty : p_disabled
  a_disabled: assert property (p_disabled)
    else $error("counter moved while disabled");

  property p_bHold;
    @(posedge core_clk) disable iff (reset)
    (s_q.bValid && !s_axi_bready) |=> s_q.bValid;
  endproperty : p_bHold
  a_bHold: assert property (p_bHold)
    else $error("write response dropped before it was taken");

  property p_rHold;
    @(posedge core_clk) disable iff (reset)
    (s_q.rValid && !s_axi_rready) |=> (s_q.rValid && $stable(s_q.rData));
  endproperty : p_rHold
  a_rHold: assert property (p_rHold)
    else $error("read data dropped before it was taken");

  assign s_axi_awready = !s_q.awDone;
  assign s_axi_wready = !s_q.wDone;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign irq = s_q.irq;
  assign faultIrq = s_q.faultIrq;
  assign allReset = s_q.allReset;
  assign procReset = s_q.procReset;
endmodule : wdmf_top
`default_nettype wire

// ==== hdl/wdmf_pkg.sv ====
// Package of register map, field layout and timing constants for the watchdog.
`default_nettype none
package wdmf_pkg;
  localparam int ADDR_W = 12;
  // Mode register sits at its printed address; the window low bits decode it.
  localparam logic [31:0] MODE_ADDR = 32'h400E_1854;
  localparam logic [ADDR_W-1:0] OFF_MODE = MODE_ADDR[ADDR_W-1:0];
  localparam logic [ADDR_W-1:0] OFF_CMD = 12'h850;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h858;
  localparam logic [ADDR_W-1:0] OFF_IRQ = 12'h860;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h864;
  localparam int RELOAD_LSB = 0;
  localparam int DELTA_LSB = 16;
  localparam int FIEN_BIT = 12;
  localparam int RSTEN_BIT = 13;
  localparam int PROC_BIT = 14;
  localparam int DIS_BIT = 15;
  localparam int DBGHLT_BIT = 28;
  localparam int IDLEHLT_BIT = 29;
  localparam int RESTART_BIT = 0;
  localparam int CNT_W = 12;
  localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
  localparam logic [31:0] MODE_MASK = 32'h3FFF_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Interrupt status bits: underflow and restart error.
  localparam int EV_UNDER = 0;
  localparam int EV_ERR = 1;
  localparam int EV_W = 2;
  // Slow clock nominal rate and derived tick divider at the 100 MHz core clock.
  localparam int CORE_HZ = 100_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int SLOW_DIV = CORE_HZ / SLOW_HZ;
endpackage : wdmf_pkg
`default_nettype wire

// ==== hdl/wdmf_tick.sv ====
// Slow clock tick generator derived from the core clock.
`default_nettype none
module wdmf_tick #(
  parameter int DIV = wdmf_pkg::SLOW_DIV
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic tick
);
  import wdmf_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wdmf_tick_t;
  wdmf_tick_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 16'(DIV - 1)) begin
      s_d.cnt = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule : wdmf_tick
`default_nettype wire

// ==== tb/tb_wdmf_top.sv ====
// Self-checking bench for the watchdog mode register and fault routing.
`default_nettype none
module tb_wdmf_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wdmf_pkg::*;
  localparam int DV = 4;
  // Configurations: error with all resets, error with processor reset only,
  // underflow after in-window restarts, underflow held off by debug halt.
  localparam logic [31:0] MW[4] = '{32'h0000_30C8, 32'h0000_60C8,
    32'h0FFF_100A, 32'h1FFF_300A};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic debugState = 1'b0, idleState = 1'b0;
  logic irq, faultIrq, allReset, procReset;
  logic sI, sA, sP;
  logic [31:0] rv, mw;
  logic [1:0] rp;
  int fail_count = 0;
  int comparisons = 0;
  wdmf_top #(.SLOW_DIV(DV)) i_dut (
    .core_clk(core_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .debugState(debugState),
    .idleState(idleState), .irq(irq), .faultIrq(faultIrq),
    .allReset(allReset), .procReset(procReset)
  );
  always #5 core_clk = ~core_clk;
  // Faults may be pulses, so they are caught in sticky flags.
  always @(posedge core_clk) begin
    if (reset) {sI, sA, sP} <= 3'b000;
    else {sI, sA, sP} <= {sI, sA, sP} | {faultIrq === 1'b1,
      allReset === 1'b1, procReset === 1'b1};
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  initial begin
    void'($urandom(32'hc55b));
    for (int k = 0; k < 4; k++) begin
      mw = MW[k];
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      debugState <= (k == 3) ? 1'b1 : 1'($urandom);
      idleState <= 1'($urandom);
      if (k == 0) begin
        rd(OFF_MODE, rv, rp);
        chk("mode reset", rv, MODE_RESET);
      end
      wr(OFF_MODE, mw);
      wr(OFF_MODE, ~mw);
      rd(OFF_MODE, rv, rp);
      chk("mode", rv, mw & MODE_MASK);
      if (k < 2) wr(OFF_CMD, 32'h0000_0001);
      else begin
        // Each restart lands well before the short count runs out.
        repeat (5) begin
          repeat (20) @(posedge core_clk);
          wr(OFF_CMD, 32'h0000_0001);
        end
        chk("restart", 32'(sI), 32'h0000_0000);
      end
      repeat (200) @(posedge core_clk);
      chk("faultIrq", 32'(sI), 32'(mw[FIEN_BIT] & (k < 3)));
      chk("allReset", 32'(sA), 32'(mw[RSTEN_BIT] & !mw[PROC_BIT] &
        !mw[DBGHLT_BIT]));
      if (mw[PROC_BIT]) chk("procReset", 32'(sP), 32'h0000_0001);
      rd(OFF_STAT, rv, rp);
      chk("status", rv, (k < 2) ? 32'(1) << EV_ERR :
        (k == 2) ? 32'(1) << EV_UNDER : 32'h0000_0000);
      chk("irq", 32'(irq), 32'(k < 3));
      wr(OFF_MASK, 32'h0000_0003);
      repeat (2) @(posedge core_clk);
      chk("irq masked", 32'(irq), 32'h0000_0000);
      wr(OFF_MASK, 32'h0000_0000);
      // A fresh in-window restart keeps a new underflow off the clear check.
      if (k >= 2) wr(OFF_CMD, 32'h0000_0001);
      wr(OFF_STAT, rv);
      rd(OFF_STAT, rv, rp);
      chk("status clear", rv, 32'h0000_0000);
      chk("irq clear", 32'(irq), 32'h0000_0000);
    end
    rd(12'h000, rv, rp);
    chk("unmapped resp", 32'(rp), 32'(RESP_SLVERR));
    end_sim;
  end
  initial begin
    #300000;
    fail_count++;
    end_sim;
  end
endmodule : tb_wdmf_top
`default_nettype wire
